// ### rtl/scpc_defs.svh
`ifndef SCPC_DEFS_SVH
`define SCPC_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SCPC_OFF_MODE    12'h000
`define SCPC_OFF_PIN     12'h004
`define SCPC_OFF_UCTL    12'h008
`define SCPC_OFF_ISTAT   12'h00C
`define SCPC_OFF_ICLR    12'h010
`define SCPC_OFF_IEN     12'h014

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCPC_B_ENABLE    0
`define SCPC_B_EIO       7
`define SCPC_B_SCK_SEL   3
`define SCPC_B_SCK_LVL   2
`define SCPC_B_TXD_SEL   1
`define SCPC_B_LINE_LVL  0
`define SCPC_B_TE        0
`define SCPC_B_RE        1
`define SCPC_B_CKE_LO    2
`define SCPC_B_CKE_HI    3
`define SCPC_B_COMM      4
`define SCPC_B_RIE       5
`define SCPC_B_I_FULL    0
`define SCPC_B_I_ERR     1

// ----------------------------------------------------------------
// Reset values and bus codes
// ----------------------------------------------------------------
`define SCPC_RST_PIN     5'h00
`define SCPC_RST_UCTL    6'h00
`define SCPC_RST_IRQ     2'h0
`define SCPC_ZERO32      32'h00000000
`define SCPC_RESP_OKAY   2'h0
`define SCPC_RESP_SLVERR 2'h2

`endif

// ### rtl/scpc_pkg.sv
package scpc_pkg;

  // ----------------------------------------------------------------
  // Pin control fields that software writes
  // ----------------------------------------------------------------
  typedef struct packed {
    logic error_irq_only;
    logic clk_pin_drive_sel;
    logic clk_pin_level;
    logic txd_pin_drive_sel;
    logic line_pin_level;
  } scpc_pin_ctrl_t;

  // ----------------------------------------------------------------
  // Unit control bits shared with the serial core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic receive_irq_enable;
    logic comm_mode;
    logic clock_source_sel_hi;
    logic clock_source_sel_lo;
    logic rx_enable_bit;
    logic tx_enable_bit;
  } scpc_unit_ctrl_t;

  // ----------------------------------------------------------------
  // Register select
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    scpc_r_none  = 3'b000,
    scpc_r_mode  = 3'b001,
    scpc_r_pin   = 3'b010,
    scpc_r_uctl  = 3'b011,
    scpc_r_istat = 3'b100,
    scpc_r_iclr  = 3'b101,
    scpc_r_ien   = 3'b110
  } scpc_reg_t;

endpackage : scpc_pkg

// ### rtl/scpc_port_ctrl.sv
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
// Operation
// - While the enable bit is 0, every register bit except that enable bit is blocked.
// - In standby the transmit and clock pins float and the receive pin is ignored.
// - Entering standby keeps all register values for when the interface is enabled again.
// - Setting the enable bit to 1 opens the registers and makes the pins operational.
// - With error-only set and receive interrupts enabled, only the error interrupt rises.
// - With error-only clear and receive interrupts enabled, both interrupts may rise.
// - With clock drive selected and clock sources and mode cleared, the clock pin shows the bit.
// - Reading the clock level bit returns the real clock pin level.
// - With transmit drive selected and both enables clear, the transmit pin shows the bit.
// - Reading the line level bit returns the current receive pin level.
// - Reserved pin control bits 15 to 8 and 6 to 4 read zero and ignore writes.
// - Level bits follow the pins after reset, the rest reset to zero; 1 means high.
// - Withdrawing an error flag withdraws the pending error interrupt; here only receive_error_irq drops, the ISTAT error bit and irq stay set.
`include "scpc_defs.svh"

module scpc_port_ctrl
  import scpc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite write
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Card pins
  input  wire logic        sck_i,
  output      logic        sck_o,
  output      logic        sck_oe_n,
  output      logic        txd_o,
  output      logic        txd_oe_n,
  input  wire logic        rxd_i,
  // Serial core side
  input  wire logic        core_sck_o,
  input  wire logic        core_sck_drive,
  input  wire logic        core_txd_o,
  input  wire logic        core_rx_full,
  input  wire logic        core_error,
  output      logic        core_rxd,
  output      logic        core_sck_rise,
  output      logic        core_sck_fall,
  output      logic        iface_enable,
  output scpc_unit_ctrl_t  unit_ctrl,
  // Interrupts
  output      logic        receive_full_irq,
  output      logic        receive_error_irq,
  output      logic        irq
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic scpc_reg_t reg_decode(input logic [11:0] addr);
    if (addr == `SCPC_OFF_MODE)
      reg_decode = scpc_r_mode;
    else if (addr == `SCPC_OFF_PIN)
      reg_decode = scpc_r_pin;
    else if (addr == `SCPC_OFF_UCTL)
      reg_decode = scpc_r_uctl;
    else if (addr == `SCPC_OFF_ISTAT)
      reg_decode = scpc_r_istat;
    else if (addr == `SCPC_OFF_ICLR)
      reg_decode = scpc_r_iclr;
    else if (addr == `SCPC_OFF_IEN)
      reg_decode = scpc_r_ien;
    else
      reg_decode = scpc_r_none;
  endfunction : reg_decode

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic            aw_have_q, aw_have_d, w_have_q, w_have_d, awready_q, awready_d;
  logic [11:0]     awaddr_q, awaddr_d;
  logic [31:0]     wdata_q, wdata_d;
  logic            wstrb0_q, wstrb0_d;
  logic            bvalid_q, bvalid_d, rvalid_q, rvalid_d, wready_q, wready_d, arready_q, arready_d;
  logic [1:0]      bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]     rdata_q, rdata_d;
  logic            enable_q, enable_d;
  scpc_pin_ctrl_t  pin_q, pin_d;
  scpc_unit_ctrl_t uctl_q, uctl_d;
  logic [1:0]      istat_q, istat_d, ien_q, ien_d;
  logic            sck_m_q, sck_s_q, sck_p_q, rxd_m_q, rxd_s_q;
  logic            sck_o_q, sck_o_d, sck_oe_n_q, sck_oe_n_d;
  logic            txd_o_q, txd_o_d, txd_oe_n_q, txd_oe_n_d;
  logic            rxd_q, rxd_d, rise_q, rise_d, fall_q, fall_d;
  logic            full_irq_q, full_irq_d, err_irq_q, err_irq_d, irq_q, irq_d;
  logic            wr_fire;
  logic [1:0]      ev;
  scpc_reg_t       wsel, rsel;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    {aw_have_d, w_have_d, wstrb0_d}        = {aw_have_q, w_have_q, wstrb0_q};
    {awaddr_d, wdata_d, rdata_d}           = {awaddr_q, wdata_q, rdata_q};
    {bvalid_d, rvalid_d, bresp_d, rresp_d} = {bvalid_q, rvalid_q, bresp_q, rresp_q};
    enable_d   = enable_q;
    {pin_d, uctl_d, ien_d}                 = {pin_q, uctl_q, ien_q};
    ev         = `SCPC_RST_IRQ;
    wsel       = reg_decode(awaddr_q);
    rsel       = reg_decode(s_axi_araddr);
    wr_fire    = aw_have_q && w_have_q && !bvalid_q;

    if (s_axi_awvalid && !aw_have_q && !bvalid_q)
    begin
      aw_have_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have_q && !bvalid_q)
    begin
      w_have_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;

    // Write: every field sits in byte lane 0
    if (wr_fire)
    begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (wsel == scpc_r_none) ? `SCPC_RESP_SLVERR : `SCPC_RESP_OKAY;
      if (wstrb0_q)
      begin
        if (wsel == scpc_r_mode)
          enable_d = wdata_q[`SCPC_B_ENABLE];
        else if (!enable_q)
          enable_d = enable_q;
        else if (wsel == scpc_r_pin)
        begin
          pin_d.error_irq_only    = wdata_q[`SCPC_B_EIO];
          pin_d.clk_pin_drive_sel = wdata_q[`SCPC_B_SCK_SEL];
          pin_d.clk_pin_level     = wdata_q[`SCPC_B_SCK_LVL];
          pin_d.txd_pin_drive_sel = wdata_q[`SCPC_B_TXD_SEL];
          pin_d.line_pin_level    = wdata_q[`SCPC_B_LINE_LVL];
        end
        else if (wsel == scpc_r_uctl)
        begin
          uctl_d.tx_enable_bit       = wdata_q[`SCPC_B_TE];
          uctl_d.rx_enable_bit       = wdata_q[`SCPC_B_RE];
          uctl_d.clock_source_sel_lo = wdata_q[`SCPC_B_CKE_LO];
          uctl_d.clock_source_sel_hi = wdata_q[`SCPC_B_CKE_HI];
          uctl_d.comm_mode           = wdata_q[`SCPC_B_COMM];
          uctl_d.receive_irq_enable  = wdata_q[`SCPC_B_RIE];
        end
        else if (wsel == scpc_r_iclr)
          ev = wdata_q[`SCPC_B_I_ERR:`SCPC_B_I_FULL];
        else if (wsel == scpc_r_ien)
          ien_d = wdata_q[`SCPC_B_I_ERR:`SCPC_B_I_FULL];
      end
    end

    // Read: one cycle from address to data
    if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
    if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_d = 1'b1;
      rdata_d  = `SCPC_ZERO32;
      rresp_d  = (rsel == scpc_r_none) ? `SCPC_RESP_SLVERR : `SCPC_RESP_OKAY;
      if (rsel == scpc_r_mode)
        rdata_d[`SCPC_B_ENABLE] = enable_q;
      // blocked bits read zero in standby
      else if (!enable_q)
        rdata_d = `SCPC_ZERO32;
      else if (rsel == scpc_r_pin)
      begin
        rdata_d[`SCPC_B_EIO]      = pin_q.error_irq_only;
        rdata_d[`SCPC_B_SCK_SEL]  = pin_q.clk_pin_drive_sel;
        rdata_d[`SCPC_B_SCK_LVL]  = sck_s_q;
        rdata_d[`SCPC_B_TXD_SEL]  = pin_q.txd_pin_drive_sel;
        rdata_d[`SCPC_B_LINE_LVL] = rxd_s_q;
      end
      else if (rsel == scpc_r_uctl)
      begin
        rdata_d[`SCPC_B_TE]     = uctl_q.tx_enable_bit;
        rdata_d[`SCPC_B_RE]     = uctl_q.rx_enable_bit;
        rdata_d[`SCPC_B_CKE_LO] = uctl_q.clock_source_sel_lo;
        rdata_d[`SCPC_B_CKE_HI] = uctl_q.clock_source_sel_hi;
        rdata_d[`SCPC_B_COMM]   = uctl_q.comm_mode;
        rdata_d[`SCPC_B_RIE]    = uctl_q.receive_irq_enable;
      end
      else if (rsel == scpc_r_istat)
        rdata_d[`SCPC_B_I_ERR:`SCPC_B_I_FULL] = istat_q;
      else if (rsel == scpc_r_ien)
        rdata_d[`SCPC_B_I_ERR:`SCPC_B_I_FULL] = ien_q;
    end
    // Ready only while the slot is empty, so a held item is never overwritten
    awready_d = !aw_have_d && !bvalid_d;
    wready_d  = !w_have_d && !bvalid_d;
    arready_d = !rvalid_d;

    // Pins
    sck_o_d    = 1'b0;
    sck_oe_n_d = 1'b1;
    txd_o_d    = 1'b0;
    txd_oe_n_d = 1'b1;
    rxd_d      = 1'b1;
    // pins float and receive held idle in standby
    if (enable_q)
    begin
      rxd_d = rxd_s_q;
      if (pin_q.clk_pin_drive_sel && !uctl_q.comm_mode &&
          !uctl_q.clock_source_sel_hi && !uctl_q.clock_source_sel_lo)
      begin
        sck_o_d    = pin_q.clk_pin_level;
        sck_oe_n_d = 1'b0;
      end
      else if (core_sck_drive)
      begin
        sck_o_d    = core_sck_o;
        sck_oe_n_d = 1'b0;
      end
      if (pin_q.txd_pin_drive_sel && !uctl_q.tx_enable_bit && !uctl_q.rx_enable_bit)
      begin
        txd_o_d    = pin_q.line_pin_level;
        txd_oe_n_d = 1'b0;
      end
      else if (uctl_q.tx_enable_bit)
      begin
        txd_o_d    = core_txd_o;
        txd_oe_n_d = 1'b0;
      end
    end
    rise_d = sck_s_q && !sck_p_q;
    fall_d = !sck_s_q && sck_p_q;

    // both requests when error only is clear
    full_irq_d = enable_q && uctl_q.receive_irq_enable && !pin_q.error_irq_only &&
                 core_rx_full;
    err_irq_d  = enable_q && uctl_q.receive_irq_enable && core_error;
    // Set beats a same-cycle clear so no event is lost
    istat_d = (istat_q & ~ev) | {err_irq_d && !err_irq_q, full_irq_d && !full_irq_q};
    irq_d   = |(istat_q & ien_q);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {aw_have_q, w_have_q, wstrb0_q, bvalid_q, rvalid_q, enable_q} <= '0;
      {sck_m_q, sck_s_q, sck_p_q, sck_o_q, txd_o_q, rise_q, fall_q} <= '0;
      {full_irq_q, err_irq_q, irq_q} <= '0;
      {rxd_m_q, rxd_s_q, rxd_q, sck_oe_n_q, txd_oe_n_q} <= '1;
      {awready_q, wready_q, arready_q} <= '1;
      awaddr_q   <= `SCPC_OFF_MODE;
      wdata_q    <= `SCPC_ZERO32;
      rdata_q    <= `SCPC_ZERO32;
      bresp_q    <= `SCPC_RESP_OKAY;
      rresp_q    <= `SCPC_RESP_OKAY;
      // level bits read the pins, stored bits clear
      pin_q      <= `SCPC_RST_PIN;
      uctl_q     <= `SCPC_RST_UCTL;
      istat_q    <= `SCPC_RST_IRQ;
      ien_q      <= `SCPC_RST_IRQ;
    end
    else if (ce)
    begin
      {aw_have_q, w_have_q, wstrb0_q} <= {aw_have_d, w_have_d, wstrb0_d};
      {bvalid_q, rvalid_q, bresp_q, rresp_q} <= {bvalid_d, rvalid_d, bresp_d, rresp_d};
      {awready_q, wready_q, arready_q} <= {awready_d, wready_d, arready_d};
      {awaddr_q, wdata_q, rdata_q} <= {awaddr_d, wdata_d, rdata_d};
      enable_q   <= enable_d;
      {pin_q, uctl_q, istat_q, ien_q} <= {pin_d, uctl_d, istat_d, ien_d};
      {sck_m_q, sck_s_q, sck_p_q} <= {sck_i, sck_m_q, sck_s_q};
      {rxd_m_q, rxd_s_q} <= {rxd_i, rxd_m_q};
      {sck_o_q, sck_oe_n_q, txd_o_q, txd_oe_n_q} <= {sck_o_d, sck_oe_n_d, txd_o_d, txd_oe_n_d};
      {rxd_q, rise_q, fall_q} <= {rxd_d, rise_d, fall_d};
      {full_irq_q, err_irq_q, irq_q} <= {full_irq_d, err_irq_d, irq_d};
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready     = awready_q;
  assign s_axi_wready      = wready_q;
  assign s_axi_arready     = arready_q;
  assign s_axi_bvalid      = bvalid_q;
  assign s_axi_bresp       = bresp_q;
  assign s_axi_rvalid      = rvalid_q;
  assign s_axi_rresp       = rresp_q;
  assign s_axi_rdata       = rdata_q;
  assign sck_o             = sck_o_q;
  assign sck_oe_n          = sck_oe_n_q;
  assign txd_o             = txd_o_q;
  assign txd_oe_n          = txd_oe_n_q;
  assign core_rxd          = rxd_q;
  assign core_sck_rise     = rise_q;
  assign core_sck_fall     = fall_q;
  assign iface_enable      = enable_q;
  assign unit_ctrl         = uctl_q;
  assign receive_full_irq  = full_irq_q;
  assign receive_error_irq = err_irq_q;
  assign irq               = irq_q;

endmodule : scpc_port_ctrl

// ### bench/scpc_port_ctrl_assertions.sv
`timescale 1ns/100ps
module scpc_chk
  import scpc_pkg::*;
(
  // Clock and reset
  input wire logic            aclk,
  input wire logic            aresetn,
  // Bus handshakes
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic [1:0]      s_axi_bresp,
  // Pins and core side
  input wire logic            sck_i,
  input wire logic            sck_oe_n,
  input wire logic            txd_oe_n,
  input wire logic            core_rxd,
  input wire logic            core_rx_full,
  input wire logic            core_error,
  input wire logic            core_sck_rise,
  input wire logic            iface_enable,
  input wire scpc_unit_ctrl_t unit_ctrl,
  input wire logic            receive_full_irq,
  input wire logic            receive_error_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_STBY_PINS: assert property (!iface_enable [*2] |-> sck_oe_n && txd_oe_n)
    else $error("pin driven in standby");
  AST_STBY_RXD: assert property (!iface_enable [*2] |-> core_rxd)
    else $error("receive data passed in standby");
  AST_SCK_OE: assert property (!sck_oe_n |-> $past(iface_enable))
    else $error("clock pin driven without enable");
  AST_ERR_IRQ: assert property (receive_error_irq ==
    $past(iface_enable && unit_ctrl.receive_irq_enable && core_error))
    else $error("error request wrong");
  AST_FULL_IRQ: assert property (receive_full_irq |->
    $past(iface_enable && unit_ctrl.receive_irq_enable && core_rx_full))
    else $error("full request without cause");
  AST_ERR_DROP: assert property ($fell(core_error) |=> !receive_error_irq)
    else $error("error request not withdrawn");
  AST_SCK_RISE: assert property ($rose(sck_i) |-> ##[1:4] core_sck_rise)
    else $error("clock pin edge missed");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");

  cover property (receive_error_irq);
  cover property (core_sck_rise);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : scpc_chk

bind scpc_port_ctrl scpc_chk u_chk (.*);

// ### bench/scpc_card_model.sv
`timescale 1ns/100ps
module scpc_card_model (
  // Device pins
  input  wire logic sck_o,
  input  wire logic sck_oe_n,
  // Bench control
  input  wire logic clk_run,
  input  wire logic rxd_val,
  // Line levels
  output wire logic sck_line,
  output wire logic rxd_line
);
  logic card_clk = 1'b0;
  // Odd offset keeps card edges off the bus clock edges
  initial
  begin
    #0.3;
    forever
    begin
      #62.5;
      card_clk = clk_run ? ~card_clk : 1'b0;
    end
  end
  assign sck_line = !sck_oe_n ? sck_o : card_clk;
  assign rxd_line = rxd_val;
endmodule : scpc_card_model

// ### bench/scpc_port_ctrl_test.sv
`timescale 1ns/100ps
`include "scpc_defs.svh"
module scpc_port_ctrl_test
  import scpc_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic sck_i, sck_o, sck_oe_n, txd_o, txd_oe_n, rxd_i, core_rxd, core_sck_rise, core_sck_fall;
  logic core_sck_o, core_sck_drive, core_txd_o, core_rx_full, core_error, iface_enable;
  logic receive_full_irq, receive_error_irq, clk_run, rxd_val;
  scpc_unit_ctrl_t unit_ctrl;
  int error_cnt = 0, compares = 0, rises = 0, falls = 0, r0, f0;

  always #5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    rises <= rises + int'(core_sck_rise);
    falls <= falls + int'(core_sck_fall);
  end

  scpc_port_ctrl DUT (.*);
  scpc_card_model u_card (.sck_o(sck_o), .sck_oe_n(sck_oe_n), .clk_run(clk_run),
    .rxd_val(rxd_val), .sck_line(sck_i), .rxd_line(rxd_i));

  // ----
  // Checks and bus tasks
  // ----
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk32

  task automatic chkb(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : chkb

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic tmo();
    error_cnt++;
    $display("wrong value bus wait expected answer seen none");
    summarize();
  endtask : tmo

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 40) tmo();
    s_axi_bready <= 1'b0;
    chk32("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr

  task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 40) tmo();
    s_axi_rready <= 1'b0;
    chk32("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    chk32("rdata", e, s_axi_rdata);
  endtask : rc

  // ----
  // Main sequence
  // ----
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
    {core_sck_o, core_sck_drive, core_txd_o, core_rx_full, core_error, clk_run} <= '0;
    ce <= 1'b1;
    s_axi_wstrb <= 4'hF;
    rxd_val <= 1'b1;
    cyc(4);
    aresetn <= 1'b1;
    rc(`SCPC_OFF_PIN, 32'h0);
    wr(`SCPC_OFF_UCTL, 32'h3F);
    wr(`SCPC_OFF_PIN, 32'hFF);
    chkb("sck_oe_n", 1'b1, sck_oe_n);
    chkb("txd_oe_n", 1'b1, txd_oe_n);
    $display("test standby done");
    wr(`SCPC_OFF_MODE, 32'h1);
    rc(`SCPC_OFF_MODE, 32'h1);
    cyc(4);
    rc(`SCPC_OFF_PIN, 32'h1);
    rc(`SCPC_OFF_UCTL, 32'h0);
    $display("test enable done");
    rxd_val <= 1'b0;
    wr(`SCPC_OFF_PIN, 32'hFFFFFFFF);
    cyc(4);
    rc(`SCPC_OFF_PIN, 32'h8E);
    chkb("sck_o", 1'b1, sck_o);
    chkb("sck_oe_n", 1'b0, sck_oe_n);
    chkb("txd_o", 1'b1, txd_o);
    chkb("txd_oe_n", 1'b0, txd_oe_n);
    rxd_val <= 1'b1;
    wr(`SCPC_OFF_PIN, 32'h0A);
    cyc(4);
    rc(`SCPC_OFF_PIN, 32'h0B);
    chkb("sck_o", 1'b0, sck_o);
    chkb("txd_o", 1'b0, txd_o);
    $display("test pin drive done");
    rxd_val <= 1'b0;
    wr(`SCPC_OFF_UCTL, 32'h1);
    cyc(3);
    chkb("core_rxd", 1'b0, core_rxd);
    // Disabled only while idle, never mid-transfer
    wr(`SCPC_OFF_MODE, 32'h0);
    cyc(3);
    chkb("sck_oe_n", 1'b1, sck_oe_n);
    chkb("txd_oe_n", 1'b1, txd_oe_n);
    chkb("core_rxd", 1'b1, core_rxd);
    rc(`SCPC_OFF_UCTL, 32'h0);
    wr(`SCPC_OFF_PIN, 32'h0);
    wr(`SCPC_OFF_MODE, 32'h1);
    cyc(4);
    rc(`SCPC_OFF_PIN, 32'h0A);
    rc(`SCPC_OFF_UCTL, 32'h1);
    $display("test retention done");
    // Clock source or transmit enable hands the pins back to the core
    core_txd_o <= 1'b1;
    core_sck_o <= 1'b1;
    core_sck_drive <= 1'b1;
    wr(`SCPC_OFF_UCTL, 32'h5);
    cyc(3);
    chkb("sck_o", 1'b1, sck_o);
    chkb("txd_o", 1'b1, txd_o);
    chk32("unit_ctrl", 32'h5, {26'h0, unit_ctrl});
    chkb("iface_enable", 1'b1, iface_enable);
    {core_sck_drive, core_sck_o, core_txd_o} <= 3'h0;
    cyc(4);
    // Low clock enable must freeze the receive path
    ce <= 1'b0;
    rxd_val <= 1'b1;
    cyc(5);
    chkb("core_rxd", 1'b0, core_rxd);
    ce <= 1'b1;
    cyc(4);
    chkb("core_rxd", 1'b1, core_rxd);
    $display("test core drive done");
    wr(`SCPC_OFF_UCTL, 32'h20);
    wr(`SCPC_OFF_IEN, 32'h3);
    core_rx_full <= 1'b1;
    cyc(5);
    chkb("full_irq", 1'b1, receive_full_irq);
    chkb("irq", 1'b1, irq);
    rc(`SCPC_OFF_ISTAT, 32'h1);
    core_rx_full <= 1'b0;
    wr(`SCPC_OFF_ICLR, 32'h1);
    cyc(3);
    chkb("irq", 1'b0, irq);
    wr(`SCPC_OFF_PIN, 32'h80);
    core_rx_full <= 1'b1;
    core_error <= 1'b1;
    cyc(5);
    chkb("full_irq", 1'b0, receive_full_irq);
    chkb("err_irq", 1'b1, receive_error_irq);
    chkb("irq", 1'b1, irq);
    rc(`SCPC_OFF_ISTAT, 32'h2);
    core_error <= 1'b0;
    cyc(3);
    chkb("err_irq", 1'b0, receive_error_irq);
    wr(`SCPC_OFF_IEN, 32'h1);
    cyc(3);
    chkb("irq", 1'b0, irq);
    wr(`SCPC_OFF_ICLR, 32'h2);
    rc(`SCPC_OFF_ISTAT, 32'h0);
    core_rx_full <= 1'b0;
    $display("test interrupts done");
    wr(12'hFFC, 32'h1, `SCPC_RESP_SLVERR);
    rc(12'hFFC, 32'h0, `SCPC_RESP_SLVERR);
    $display("test unmapped done");
    r0 = rises;
    f0 = falls;
    clk_run <= 1'b1;
    cyc(100);
    clk_run <= 1'b0;
    cyc(20);
    chk32("sck rises", 32'd8, 32'(rises - r0));
    chk32("sck falls", 32'd8, 32'(falls - f0));
    $display("test link clock done");
    summarize();
  end
endmodule : scpc_port_ctrl_test
